// *** design/acs_avg_if.sv ***
`timescale 1ns/1ps
interface acs_avg_if;
  logic active;
  logic clear;
  logic ref_sel;
  logic [2:0] os_depth;
  logic [12:0] corr;

  modport ctl (output active, output clear, output ref_sel, output os_depth, input corr);
  modport avg (input active, input clear, input ref_sel, input os_depth, output corr);
endinterface : acs_avg_if

// *** design/acs_cal_regs.sv ***
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_cal_regs (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [11:0] primary_sample,
  input wire logic [11:0] spare_sample,
  output logic [12:0] offset_correction,
  output logic foreground_finished_flag,
  output logic background_halted_flag,
  output logic cal_irq
);
  acs_pkg::acs_regs_type st_r;
  acs_pkg::acs_regs_type st_nxt;
  acs_avg_if avg_bus ();

  logic run;
  logic background_calib_enable;
  logic foreground_calib_enable;
  logic halt_req;
  logic [1:0] halt_phase;
  logic offset_reference_select;
  logic [2:0] offset_avg_depth;
  logic [2:0] linearity_avg_depth;
  logic [11:0] phase_len;
  logic [11:0] phase_lim;
  logic phase_end;
  logic in_fg;
  logic in_bg;
  logic [2:0] stat_code;
  logic [1:0] irq_ev;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  assign run = st_r.ctrl[`ACS_CTRL_RUN];
  assign background_calib_enable = st_r.ctrl[`ACS_CTRL_BG];
  assign foreground_calib_enable = st_r.ctrl[`ACS_CTRL_FG];
  assign halt_req = st_r.ctrl[`ACS_CTRL_HALT];
  assign halt_phase = st_r.ctrl[`ACS_CTRL_HPH_MSB:`ACS_CTRL_HPH_LSB];
  assign offset_reference_select = st_r.setup[`ACS_REF_SEL_BIT];
  assign offset_avg_depth = st_r.avg[`ACS_OFS_DEPTH_MSB:`ACS_OFS_DEPTH_LSB];
  assign linearity_avg_depth = st_r.avg[`ACS_LIN_AVG_MSB:`ACS_LIN_AVG_LSB];

  // each phase lasts base << depth cycles, at most 2048
  assign phase_len = `ACS_PHASE_BASE << linearity_avg_depth;
  assign phase_lim = phase_len - 12'h001;
  assign phase_end = st_r.phase_cnt == phase_lim;
  assign in_fg = st_r.state == acs_pkg::ACS_FORE;
  assign in_bg = st_r.state == acs_pkg::ACS_BACK;

  always_comb begin
    unique case (st_r.state)
      acs_pkg::ACS_HOLD: stat_code = `ACS_STAT_HOLD;
      acs_pkg::ACS_FORE: stat_code = `ACS_STAT_FORE;
      acs_pkg::ACS_BACK: stat_code = `ACS_STAT_BACK;
      acs_pkg::ACS_HALTED: stat_code = `ACS_STAT_HALTED;
      acs_pkg::ACS_STILL: stat_code = `ACS_STAT_STILL;
      default: stat_code = `ACS_STAT_HOLD;
    endcase
  end

  // ----------------------------------------
  // offset averaging engine
  // ----------------------------------------
  assign avg_bus.active = in_fg || in_bg;
  assign avg_bus.clear = st_r.state == acs_pkg::ACS_HOLD;
  assign avg_bus.ref_sel = offset_reference_select;
  assign avg_bus.os_depth = offset_avg_depth;

  acs_offset_avg u_offset_avg (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .bus(avg_bus),
    .primary_sample(primary_sample),
    .spare_sample(spare_sample)
  );

  // ----------------------------------------
  // sequencer, register file, interrupt
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;

    unique case (st_r.state)
      acs_pkg::ACS_HOLD: begin
        // calibration values cleared while held
        st_nxt.phase_cnt = 12'h000;
        st_nxt.phase_idx = 2'h0;
        st_nxt.fore_done = 1'b0;
        st_nxt.stopped = 1'b0;
        if (foreground_calib_enable) begin
          st_nxt.state = acs_pkg::ACS_FORE;
        end else begin
          st_nxt.fore_done = 1'b1;
          if (background_calib_enable) begin
            st_nxt.state = acs_pkg::ACS_BACK;
          end else begin
            st_nxt.state = acs_pkg::ACS_STILL;
            st_nxt.stopped = 1'b1;
          end
        end
      end
      acs_pkg::ACS_FORE: begin
        st_nxt.phase_cnt = st_r.phase_cnt + 12'h001;
        if (phase_end) begin
          st_nxt.phase_cnt = 12'h000;
          st_nxt.fore_done = 1'b1;
          if (background_calib_enable) begin
            st_nxt.state = acs_pkg::ACS_BACK;
          end else begin
            st_nxt.state = acs_pkg::ACS_STILL;
            st_nxt.stopped = 1'b1;
          end
        end
      end
      acs_pkg::ACS_BACK: begin
        if (!background_calib_enable) begin
          st_nxt.state = acs_pkg::ACS_STILL;
          st_nxt.stopped = 1'b1;
        end else begin
          st_nxt.phase_cnt = st_r.phase_cnt + 12'h001;
          if (phase_end) begin
            st_nxt.phase_cnt = 12'h000;
            st_nxt.phase_idx = st_r.phase_idx + 2'h1;
            // stop only on a phase boundary so the trims stay coherent
            if (halt_req && st_r.phase_idx == halt_phase) begin
              st_nxt.state = acs_pkg::ACS_HALTED;
              st_nxt.stopped = 1'b1;
            end
          end
        end
      end
      acs_pkg::ACS_HALTED: begin
        if (!background_calib_enable) begin
          st_nxt.state = acs_pkg::ACS_STILL;
        end else if (!halt_req) begin
          st_nxt.state = acs_pkg::ACS_BACK;
          st_nxt.stopped = 1'b0;
        end
      end
      acs_pkg::ACS_STILL: begin
        if (background_calib_enable) begin
          st_nxt.state = acs_pkg::ACS_BACK;
          st_nxt.stopped = 1'b0;
        end
      end
    endcase

    if (!run) begin
      st_nxt.state = acs_pkg::ACS_HOLD;
      st_nxt.phase_cnt = 12'h000;
      st_nxt.phase_idx = 2'h0;
      st_nxt.fore_done = 1'b0;
      st_nxt.stopped = 1'b0;
    end

    if (reg_rd) begin
      case (reg_addr)
        `ACS_ADDR_SETUP: st_nxt.rdata = st_r.setup;
        `ACS_ADDR_AVG: st_nxt.rdata = st_r.avg;
        `ACS_ADDR_STATE: st_nxt.rdata = {3'h0, stat_code, st_r.stopped, st_r.fore_done};
        `ACS_ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
        `ACS_ADDR_IRQ_STAT: st_nxt.rdata = {6'h00, st_r.irq_stat};
        `ACS_ADDR_IRQ_MASK: st_nxt.rdata = {6'h00, st_r.irq_mask};
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        `ACS_ADDR_SETUP: st_nxt.setup = reg_wdata;
        `ACS_ADDR_AVG: st_nxt.avg = reg_wdata;
        `ACS_ADDR_CTRL: st_nxt.ctrl = reg_wdata;
        `ACS_ADDR_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[1:0];
        `ACS_ADDR_IRQ_MASK: st_nxt.irq_mask = reg_wdata[1:0];
        default: st_nxt.irq_mask = st_nxt.irq_mask; // status and unmapped: no effect
      endcase
    end

    // events taken inside this process, so no loop through a separate net
    irq_ev[`ACS_IRQ_FG] = st_nxt.fore_done && !st_r.fore_done;
    irq_ev[`ACS_IRQ_STOP] = st_nxt.stopped && !st_r.stopped;
    // a flag rising in the clearing cycle is kept: set beats clear
    st_nxt.irq_stat = st_nxt.irq_stat | irq_ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.setup <= `ACS_SETUP_RST;
      st_r.avg <= `ACS_AVG_RST;
      st_r.ctrl <= `ACS_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign offset_correction = avg_bus.corr;
  assign foreground_finished_flag = st_r.fore_done;
  assign background_halted_flag = st_r.stopped;
  assign cal_irq = st_r.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_halt_point;
    in_bg && run && background_calib_enable && halt_req && st_r.phase_idx == halt_phase && phase_end;
  endsequence

  sequence s_halted;
    st_r.stopped && st_r.state == acs_pkg::ACS_HALTED;
  endsequence

  property p_halt;
    s_halt_point |=> s_halted;
  endproperty
  a_halt: assert property (p_halt) else $error("background did not halt at requested phase");

  property p_resume;
    (s_halted ##0 run && background_calib_enable && !halt_req) |=> !st_r.stopped ##0 in_bg;
  endproperty
  a_resume: assert property (p_resume) else $error("halted flag kept after resume");

  property p_bg_off;
    ($rose(st_r.fore_done) && !$past(background_calib_enable)) |-> st_r.stopped;
  endproperty
  a_bg_off: assert property (p_bg_off) else $error("halted flag missing with background off");

  property p_fg_skip;
    (st_r.state == acs_pkg::ACS_HOLD && run && !foreground_calib_enable) |=> st_r.fore_done && !in_fg;
  endproperty
  a_fg_skip: assert property (p_fg_skip) else $error("skipped foreground not flagged");

  property p_bg_only;
    in_bg |-> $past(background_calib_enable);
  endproperty
  a_bg_only: assert property (p_bg_only) else $error("background ran while disabled");

  property p_hold;
    !run |=> st_r.state == acs_pkg::ACS_HOLD && !st_r.fore_done && !st_r.stopped;
  endproperty
  a_hold: assert property (p_hold) else $error("calibration not held in reset");

  property p_fg_len;
    ($rose(in_fg) && linearity_avg_depth == 3'h0) |-> in_fg [*8] ##1 in_fg [*8] ##1 !in_fg;
  endproperty
  a_fg_len: assert property (p_fg_len) else $error("foreground length wrong for depth zero");

  property p_status_ro;
    (reg_wr && reg_addr == 8'h6a) |=> $stable(st_r.setup) && $stable(st_r.avg) && $stable(st_r.ctrl);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write disturbed registers");

  property p_irq;
    cal_irq == |(st_r.irq_stat & st_r.irq_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output disagrees with status and mask");

endmodule : acs_cal_regs

// *** design/acs_defs.svh ***
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACS_ADDR_SETUP 8'h65
`define ACS_ADDR_AVG 8'h68
`define ACS_ADDR_STATE 8'h6a
`define ACS_ADDR_CTRL 8'h70
`define ACS_ADDR_IRQ_STAT 8'h71
`define ACS_ADDR_IRQ_MASK 8'h72

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACS_SETUP_RST 8'h01
`define ACS_AVG_RST 8'h61
`define ACS_CTRL_RST 8'h05

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACS_REF_SEL_BIT 2
`define ACS_OFS_DEPTH_MSB 6
`define ACS_OFS_DEPTH_LSB 4
`define ACS_LIN_AVG_MSB 2
`define ACS_LIN_AVG_LSB 0
`define ACS_CTRL_RUN 0
`define ACS_CTRL_BG 1
`define ACS_CTRL_FG 2
`define ACS_CTRL_HALT 3
`define ACS_CTRL_HPH_MSB 5
`define ACS_CTRL_HPH_LSB 4
`define ACS_IRQ_FG 0
`define ACS_IRQ_STOP 1

// ----------------------------------------
// calibration constants
// ----------------------------------------
`define ACS_MID_CODE 12'h800
`define ACS_PHASE_BASE 12'h010
`define ACS_STAT_HOLD 3'h0
`define ACS_STAT_FORE 3'h1
`define ACS_STAT_BACK 3'h2
`define ACS_STAT_HALTED 3'h3
`define ACS_STAT_STILL 3'h4

`endif

// *** design/acs_offset_avg.sv ***
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_offset_avg (
  input wire logic core_clk,
  input wire logic reset_n,
  acs_avg_if.avg bus,
  input wire logic [11:0] primary_sample,
  input wire logic [11:0] spare_sample
);
  acs_pkg::acs_avg_st_type st_r;
  acs_pkg::acs_avg_st_type st_nxt;
  logic [11:0] target;
  logic [12:0] delta;
  logic [19:0] acc_sum;
  logic [19:0] acc_shr;
  logic [7:0] win_len;
  logic [6:0] os_lim;

  // ----------------------------------------
  // offset target and averaging window
  // ----------------------------------------
  assign target = bus.ref_sel ? spare_sample : `ACS_MID_CODE;
  assign delta = {1'b0, primary_sample} - {1'b0, target};
  assign acc_sum = st_r.acc + {{7{delta[12]}}, delta};
  assign acc_shr = $signed(acc_sum) >>> bus.os_depth;
  assign win_len = 8'h01 << bus.os_depth;
  assign os_lim = 7'(win_len - 8'h01);
  assign bus.corr = st_r.corr;

  always_comb begin
    st_nxt = st_r;
    if (bus.clear) begin
      st_nxt = '0;
    end else if (bus.active) begin
      // deeper averaging: longer window, less noise, slower tracking
      if (st_r.os_cnt >= os_lim) begin
        st_nxt.corr = acc_shr[12:0];
        st_nxt.acc = 20'h00000;
        st_nxt.os_cnt = 7'h00;
      end else begin
        st_nxt.acc = acc_sum;
        st_nxt.os_cnt = st_r.os_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // checked on the correction itself, so a wrong target mux cannot hide
  property p_ref_mid;
    (bus.active && !bus.ref_sel && bus.os_depth == 3'h0) |=>
      bus.corr == ({1'b0, $past(primary_sample)} - 13'h0800);
  endproperty
  a_ref_mid: assert property (p_ref_mid) else $error("mid code not used as offset target");

  property p_ref_spare;
    (bus.active && bus.ref_sel && bus.os_depth == 3'h0) |=>
      bus.corr == ({1'b0, $past(primary_sample)} - {1'b0, $past(spare_sample)});
  endproperty
  a_ref_spare: assert property (p_ref_spare) else $error("spare samples not used as target");

  property p_os_single;
    (bus.active && !bus.clear && bus.os_depth == 3'h0 && st_r.os_cnt == 7'h00) |=> bus.corr == $past(delta);
  endproperty
  a_os_single: assert property (p_os_single) else $error("depth zero must track one sample");

  property p_os_hold;
    (bus.active && !bus.clear && st_r.os_cnt < os_lim) |=> $stable(bus.corr);
  endproperty
  a_os_hold: assert property (p_os_hold) else $error("correction changed inside window");

endmodule : acs_offset_avg

// *** design/acs_pkg.sv ***
package acs_pkg;

  typedef enum logic [2:0] {
    ACS_HOLD,
    ACS_FORE,
    ACS_BACK,
    ACS_HALTED,
    ACS_STILL
  } acs_state_type;

  typedef struct packed {
    acs_state_type state;
    logic [11:0] phase_cnt;
    logic [1:0] phase_idx;
    logic fore_done;
    logic stopped;
    logic [7:0] setup;
    logic [7:0] avg;
    logic [7:0] ctrl;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
  } acs_regs_type;

  typedef struct packed {
    logic [6:0] os_cnt;
    logic [19:0] acc;
    logic [12:0] corr;
  } acs_avg_st_type;

endpackage : acs_pkg

// *** test/acs_cal_regs_tb.sv ***
`timescale 1ns/1ps
module acs_cal_regs_tb;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} acs_row_type;
  logic core_clk, reset_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] primary_sample, spare_sample;
  logic [12:0] offset_correction;
  logic foreground_finished_flag, background_halted_flag, cal_irq;
  int failures = 0;
  int checks_done = 0;
  int n;
  acs_row_type rows [6];

  acs_cal_regs acs_cal_regs_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .primary_sample(primary_sample),
    .spare_sample(spare_sample),
    .offset_correction(offset_correction),
    .foreground_finished_flag(foreground_finished_flag),
    .background_halted_flag(background_halted_flag),
    .cal_irq(cal_irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test();
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data are looked at only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, exp});
  endtask : rdc

  task automatic cycles(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cycles

  // bounded wait on one of the two flags; n returns cycles spent
  task automatic wait_flag(input bit halted_sel, input logic val, output int cnt);
    cnt = 0;
    while ((halted_sel ? background_halted_flag : foreground_finished_flag) !== val && cnt < 300) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (cnt >= 300) begin
      failures++;
      finish_test();
    end
  endtask : wait_flag

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    primary_sample = 12'h800;
    spare_sample = 12'h800;
    // reserved bits written with their reset values, except ctrl bit 6 set by the first row
    rows = '{'{8'h70, 8'h45, 8'h45}, '{8'h65, 8'h01, 8'h01}, '{8'h68, 8'h72, 8'h72},
             '{8'h68, 8'h61, 8'h61}, '{8'h40, 8'hff, 8'h00}, '{8'h72, 8'h00, 8'h00}};
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rdc(8'h65, 8'h01);
    rdc(8'h68, 8'h61);
    rdc(8'h70, 8'h05);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdc(rows[i].addr, rows[i].exp);
    end
    wait_flag(1'b0, 1'b1, n);
    cycles(2);
    check("halted after fg", background_halted_flag, 1'b1);
    rdc(8'h6a, 8'h13);
    wr(8'h6a, 8'hff);
    rdc(8'h6a, 8'h13);
    rdc(8'h71, 8'h03);
    check("irq masked", cal_irq, 1'b0);
    wr(8'h72, 8'h01);
    cycles(1);
    check("irq unmasked", cal_irq, 1'b1);
    wr(8'h71, 8'h03);
    cycles(1);
    check("irq cleared", cal_irq, 1'b0);
    rdc(8'h71, 8'h00);
    // mid-code target, shortest windows
    wr(8'h68, 8'h00);
    wr(8'h70, 8'h04);
    cycles(2);
    check("hold fg", foreground_finished_flag, 1'b0);
    check("hold halted", background_halted_flag, 1'b0);
    check("hold corr", offset_correction, 13'h0000);
    @(posedge core_clk);
    primary_sample <= 12'h805;
    wr(8'h70, 8'h05);
    wait_flag(1'b0, 1'b1, n);
    check("fg length depth0", n[15:0], 16'h0011);
    check("corr mid", offset_correction, 13'h0005);
    // spare reference, run with background enabled
    wr(8'h70, 8'h00);
    wr(8'h70, 8'h07);
    wr(8'h65, 8'h05);
    rdc(8'h65, 8'h05);
    @(posedge core_clk);
    spare_sample <= 12'h7f0;
    cycles(40);
    check("corr spare", offset_correction, 13'h0015);
    check("bg running", background_halted_flag, 1'b0);
    rdc(8'h6a, 8'h09);
    wr(8'h70, 8'h2f);
    wait_flag(1'b1, 1'b1, n);
    rdc(8'h6a, 8'h0f);
    wr(8'h70, 8'h07);
    cycles(3);
    check("resume", background_halted_flag, 1'b0);
    wr(8'h65, 8'h01);
    wr(8'h70, 8'h05);
    cycles(3);
    check("bg off", background_halted_flag, 1'b1);
    // deeper offset window keeps correction cleared longer
    wr(8'h68, 8'h70);
    wr(8'h70, 8'h04);
    wr(8'h70, 8'h05);
    cycles(20);
    check("corr depth7", offset_correction, 13'h0000);
    wr(8'h68, 8'h02);
    wr(8'h70, 8'h04);
    wr(8'h70, 8'h05);
    wait_flag(1'b0, 1'b1, n);
    check("fg length depth2", n[15:0], 16'h0041);
    // foreground skipped
    wr(8'h70, 8'h00);
    wr(8'h70, 8'h01);
    wait_flag(1'b0, 1'b1, n);
    check("fg skip fast", n[15:0], 16'h0001);
    cycles(2);
    check("halted on skip", background_halted_flag, 1'b1);
    // second reset in mid-run
    @(posedge core_clk);
    reset_n <= 1'b0;
    cycles(2);
    check("rst fg", foreground_finished_flag, 1'b0);
    check("rst halted", background_halted_flag, 1'b0);
    check("rst irq", cal_irq, 1'b0);
    @(posedge core_clk);
    reset_n <= 1'b1;
    rdc(8'h65, 8'h01);
    rdc(8'h68, 8'h61);
    finish_test();
  end
endmodule : acs_cal_regs_tb
